//--- pkg/pdc_consts.svh
`ifndef PDC_CONSTS_SVH
`define PDC_CONSTS_SVH
// Per-channel register offsets, channel stride is 0x40
`define PDC_OFF_PTR 6'h00
`define PDC_OFF_PSEL 6'h04
`define PDC_OFF_CNT 6'h08
`define PDC_OFF_RPTR 6'h0C
`define PDC_OFF_RCNT 6'h10
`define PDC_OFF_CTRL 6'h14
`define PDC_OFF_MODE 6'h18
`define PDC_OFF_STATE 6'h1C
`define PDC_OFF_MSET 6'h20
`define PDC_OFF_MCLR 6'h24
`define PDC_OFF_MASK 6'h28
`define PDC_OFF_FLAGS 6'h2C
// Address fields
`define PDC_CH_LSB 6
`define PDC_CH_MSB 11
// Control bits
`define PDC_BIT_ON 0
`define PDC_BIT_OFF 1
`define PDC_BIT_ECLR 8
// Mode: width in [1:0], wrap bit
`define PDC_BIT_WRAP 2
// Peripheral select: [3:0] handshake index, bit 4 set means peripheral to memory
`define PDC_BIT_DIR 4
// Item widths
`define PDC_W_BYTE 2'h0
`define PDC_W_HALF 2'h1
`define PDC_W_WORD 2'h2
// Flag bit positions
`define PDC_FLG_RZ 0
`define PDC_FLG_FIN 1
`define PDC_FLG_ERR 2
// Reset values
`define PDC_RST_WORD 32'h0000_0000
`define PDC_RST_CNT 16'h0000
`define PDC_RST_PSEL 5'h00
`define PDC_RST_MODE 3'h0
`define PDC_RST_MASK 3'h0
// AHB transfer type
`define PDC_AHB_NONSEQ 2'h2
`endif

//--- pkg/pdc_pkg.sv
`include "pdc_consts.svh"
package pdc_pkg;
	typedef enum logic [2:0] {S_IDLE, S_PRD, S_PCAP, S_MRD, S_MWR, S_PWR} pdc_state_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pdc_mem_req_t;
	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} pdc_mem_rsp_t;
	typedef struct packed {
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] wdata;
	} pdc_per_req_t;
	typedef struct packed {
		logic hit;
		logic [5:0] ch;
		logic [5:0] off;
	} pdc_reg_sel_t;
endpackage

//--- core/pdc_top.sv
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module pdc_top #(
	parameter int NCH = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic clk_run,
	input wire logic [15:0] periph_req,
	output logic [15:0] periph_ack,
	output pdc_pkg::pdc_per_req_t per_req,
	input wire logic [31:0] per_rdata,
	output pdc_pkg::pdc_mem_req_t mem_req,
	input wire pdc_pkg::pdc_mem_rsp_t mem_rsp,
	output logic [NCH-1:0] chan_irq
);
	import pdc_pkg::*;
	localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] step(input logic [1:0] w);
		case (w)
			`PDC_W_BYTE: step = 32'h0000_0001;
			`PDC_W_HALF: step = 32'h0000_0002;
			default: step = 32'h0000_0004;
		endcase
	endfunction

	// Pick the addressed lane and zero the bits above the item width
	function automatic logic [31:0] lane_get(input logic [31:0] d, input logic [1:0] a,
		input logic [1:0] w);
		logic [31:0] sh;
		sh = d >> {a, 3'b000};
		case (w)
			`PDC_W_BYTE: lane_get = {24'h00_0000, sh[7:0]};
			`PDC_W_HALF: lane_get = {16'h0000, sh[15:0]};
			default: lane_get = d;
		endcase
	endfunction

	// Replicate across lanes so any aligned address sees the item
	function automatic logic [31:0] lane_put(input logic [31:0] d, input logic [1:0] w);
		case (w)
			`PDC_W_BYTE: lane_put = {4{d[7:0]}};
			`PDC_W_HALF: lane_put = {2{d[15:0]}};
			default: lane_put = d;
		endcase
	endfunction

	function automatic pdc_reg_sel_t decode(input logic [31:0] a);
		decode.ch = a[`PDC_CH_MSB:`PDC_CH_LSB];
		decode.off = a[5:0];
		decode.hit = (a[31:12] == 20'h0_0000) && (int'(decode.ch) < NCH)
			&& (decode.off <= `PDC_OFF_FLAGS);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [31:0] ptr_reg [NCH], ptr_next [NCH];
	logic [31:0] rptr_reg [NCH], rptr_next [NCH];
	logic [15:0] cnt_reg [NCH], cnt_next [NCH];
	logic [15:0] rcnt_reg [NCH], rcnt_next [NCH];
	logic [4:0] psel_reg [NCH], psel_next [NCH];
	logic [2:0] mode_reg [NCH], mode_next [NCH];
	logic [2:0] mask_reg [NCH], mask_next [NCH];
	logic [NCH-1:0] on_reg, on_next, err_reg, err_next, irq_reg, irq_next;
	logic wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
	pdc_reg_sel_t wr_sel_reg, wr_sel_next, rd_sel_reg, rd_sel_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic hreadyout_reg, hreadyout_next;
	pdc_state_t st_reg, st_next;
	logic [CHW-1:0] cur_reg, cur_next, gch;
	logic gv, xfer_done, xfer_err;
	pdc_mem_req_t mreq_reg, mreq_next;
	pdc_per_req_t preq_reg, preq_next;
	logic [15:0] ack_reg, ack_next;
	logic [2:0] flags [NCH];

	// ------------------------------------------------------------
	// Register bus slave
	// ------------------------------------------------------------
	// Reads take one wait state so a read right after a write sees the new value
	always_comb
	begin
		wr_pend_next = 1'b0;
		rd_pend_next = 1'b0;
		wr_sel_next = wr_sel_reg;
		rd_sel_next = rd_sel_reg;
		hrdata_next = hrdata_reg;
		hreadyout_next = 1'b1;
		if (hsel && hready && htrans == `PDC_AHB_NONSEQ)
		begin
			if (hwrite)
			begin
				wr_pend_next = 1'b1;
				wr_sel_next = decode(haddr);
			end
			else
			begin
				rd_pend_next = 1'b1;
				rd_sel_next = decode(haddr);
				hreadyout_next = 1'b0;
			end
		end
		if (rd_pend_reg)
		begin
			hrdata_next = `PDC_RST_WORD;
			if (rd_sel_reg.hit)
			begin
				case (rd_sel_reg.off)
					`PDC_OFF_PTR: hrdata_next = ptr_reg[rd_sel_reg.ch[CHW-1:0]];
					`PDC_OFF_PSEL: hrdata_next = {27'h000_0000, psel_reg[rd_sel_reg.ch[CHW-1:0]]};
					`PDC_OFF_CNT: hrdata_next = {16'h0000, cnt_reg[rd_sel_reg.ch[CHW-1:0]]};
					`PDC_OFF_RPTR: hrdata_next = rptr_reg[rd_sel_reg.ch[CHW-1:0]];
					`PDC_OFF_RCNT: hrdata_next = {16'h0000, rcnt_reg[rd_sel_reg.ch[CHW-1:0]]};
					`PDC_OFF_MODE: hrdata_next = {29'h0000_0000, mode_reg[rd_sel_reg.ch[CHW-1:0]]};
					`PDC_OFF_STATE: hrdata_next = {31'h0000_0000, on_reg[rd_sel_reg.ch[CHW-1:0]]};
					`PDC_OFF_MASK: hrdata_next = {29'h0000_0000, mask_reg[rd_sel_reg.ch[CHW-1:0]]};
					`PDC_OFF_FLAGS: hrdata_next = {29'h0000_0000, flags[rd_sel_reg.ch[CHW-1:0]]};
					default: hrdata_next = `PDC_RST_WORD;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Channel registers
	// ------------------------------------------------------------
	always_comb
	begin
		on_next = on_reg;
		err_next = err_reg;
		irq_next = irq_reg;
		for (int c = 0; c < NCH; c++)
		begin
			ptr_next[c] = ptr_reg[c];
			rptr_next[c] = rptr_reg[c];
			cnt_next[c] = cnt_reg[c];
			rcnt_next[c] = rcnt_reg[c];
			psel_next[c] = psel_reg[c];
			mode_next[c] = mode_reg[c];
			mask_next[c] = mask_reg[c];
			flags[c] = {err_reg[c], (cnt_reg[c] == `PDC_RST_CNT) && (rcnt_reg[c] == `PDC_RST_CNT),
				rcnt_reg[c] == `PDC_RST_CNT};
			irq_next[c] = |(flags[c] & mask_reg[c]);
			if (xfer_done && cur_reg == c[CHW-1:0] && cnt_reg[c] != `PDC_RST_CNT)
			begin
				ptr_next[c] = ptr_reg[c] + step(mode_reg[c][1:0]);
				cnt_next[c] = cnt_reg[c] - 16'h0001;
			end
			else if (cnt_reg[c] == `PDC_RST_CNT && rcnt_reg[c] != `PDC_RST_CNT)
			begin
				ptr_next[c] = rptr_reg[c];
				cnt_next[c] = rcnt_reg[c];
				if (!mode_reg[c][`PDC_BIT_WRAP])
				begin
					rptr_next[c] = `PDC_RST_WORD;
					rcnt_next[c] = `PDC_RST_CNT;
				end
			end
			if (wr_pend_reg && wr_sel_reg.hit && wr_sel_reg.ch[CHW-1:0] == c[CHW-1:0])
			begin
				case (wr_sel_reg.off)
					`PDC_OFF_PTR: ptr_next[c] = hwdata;
					`PDC_OFF_PSEL: psel_next[c] = hwdata[4:0];
					`PDC_OFF_CNT: cnt_next[c] = hwdata[15:0];
					`PDC_OFF_RPTR: rptr_next[c] = hwdata;
					`PDC_OFF_RCNT:
					begin
						rcnt_next[c] = hwdata[15:0];
						if (cnt_reg[c] == `PDC_RST_CNT && hwdata[15:0] != `PDC_RST_CNT)
						begin
							cnt_next[c] = hwdata[15:0];
							ptr_next[c] = rptr_reg[c];
							if (!mode_reg[c][`PDC_BIT_WRAP])
								rcnt_next[c] = `PDC_RST_CNT;
							if (!mode_reg[c][`PDC_BIT_WRAP])
								rptr_next[c] = `PDC_RST_WORD;
						end
					end
					`PDC_OFF_MODE: mode_next[c] = hwdata[2:0];
					`PDC_OFF_CTRL:
					begin
						// on and off bits, off wins
						if (hwdata[`PDC_BIT_ON])
							on_next[c] = 1'b1;
						if (hwdata[`PDC_BIT_OFF])
							on_next[c] = 1'b0;
						if (hwdata[`PDC_BIT_ECLR])
							err_next[c] = 1'b0;
					end
					`PDC_OFF_MSET: mask_next[c] = mask_reg[c] | hwdata[2:0];
					`PDC_OFF_MCLR: mask_next[c] = mask_reg[c] & ~hwdata[2:0];
					default: ptr_next[c] = ptr_next[c];
				endcase
			end
			if (xfer_err && cur_reg == c[CHW-1:0])
				err_next[c] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Arbiter and transfer engine
	// ------------------------------------------------------------
	always_comb
	begin
		gv = 1'b0;
		gch = '0;
		// lowest channel wins; serve while items remain
		for (int c = NCH - 1; c >= 0; c--)
		begin
			if (on_reg[c] && !err_reg[c] && cnt_reg[c] != `PDC_RST_CNT
				&& periph_req[psel_reg[c][3:0]])
			begin
				gv = 1'b1;
				gch = c[CHW-1:0];
			end
		end
	end

	always_comb
	begin
		st_next = st_reg;
		cur_next = cur_reg;
		mreq_next = mreq_reg;
		preq_next = preq_reg;
		ack_next = 16'h0000;
		xfer_done = 1'b0;
		xfer_err = 1'b0;
		// a held clock freezes the sequence in place
		if (clk_run)
		begin
			case (st_reg)
				S_IDLE:
				begin
					if (gv)
					begin
						cur_next = gch;
						ack_next[psel_reg[gch][3:0]] = 1'b1;
						// select sets direction and holding register
						preq_next.sel = psel_reg[gch][3:0];
						if (psel_reg[gch][`PDC_BIT_DIR])
						begin
							preq_next.stb = 1'b1;
							preq_next.we = 1'b0;
							st_next = S_PRD;
						end
						else
						begin
							mreq_next.valid = 1'b1;
							mreq_next.write = 1'b0;
							mreq_next.size = mode_reg[gch][1:0];
							mreq_next.addr = ptr_reg[gch];
							st_next = S_MRD;
						end
					end
				end
				S_PRD:
				begin
					preq_next.stb = 1'b0;
					st_next = S_PCAP;
				end
				S_PCAP:
				begin
					mreq_next.valid = 1'b1;
					mreq_next.write = 1'b1;
					mreq_next.size = mode_reg[cur_reg][1:0];
					mreq_next.addr = ptr_reg[cur_reg];
					mreq_next.wdata = lane_put(lane_get(per_rdata, 2'b00, mode_reg[cur_reg][1:0]),
						mode_reg[cur_reg][1:0]);
					st_next = S_MWR;
				end
				S_MRD:
				begin
					if (mem_rsp.ack)
					begin
						mreq_next.valid = 1'b0;
						if (mem_rsp.err)
						begin
							xfer_err = 1'b1;
							st_next = S_IDLE;
						end
						else
						begin
							preq_next.stb = 1'b1;
							preq_next.we = 1'b1;
							preq_next.wdata = lane_get(mem_rsp.rdata, mreq_reg.addr[1:0],
								mode_reg[cur_reg][1:0]);
							st_next = S_PWR;
						end
					end
				end
				S_MWR:
				begin
					if (mem_rsp.ack)
					begin
						mreq_next.valid = 1'b0;
						xfer_err = mem_rsp.err;
						xfer_done = !mem_rsp.err;
						st_next = S_IDLE;
					end
				end
				S_PWR:
				begin
					preq_next.stb = 1'b0;
					xfer_done = 1'b1;
					st_next = S_IDLE;
				end
				default: st_next = S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				ptr_reg[c] <= `PDC_RST_WORD;
				rptr_reg[c] <= `PDC_RST_WORD;
				cnt_reg[c] <= `PDC_RST_CNT;
				rcnt_reg[c] <= `PDC_RST_CNT;
				psel_reg[c] <= `PDC_RST_PSEL;
				mode_reg[c] <= `PDC_RST_MODE;
				mask_reg[c] <= `PDC_RST_MASK;
			end
			on_reg <= '0;
			err_reg <= '0;
			irq_reg <= '0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			wr_sel_reg <= '0;
			rd_sel_reg <= '0;
			hrdata_reg <= `PDC_RST_WORD;
			hreadyout_reg <= 1'b1;
			st_reg <= S_IDLE;
			cur_reg <= '0;
			mreq_reg <= '0;
			preq_reg <= '0;
			ack_reg <= 16'h0000;
		end
		else
		begin
			ptr_reg <= ptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
			rcnt_reg <= rcnt_next;
			psel_reg <= psel_next;
			mode_reg <= mode_next;
			mask_reg <= mask_next;
			on_reg <= on_next;
			err_reg <= err_next;
			irq_reg <= irq_next;
			wr_pend_reg <= wr_pend_next;
			rd_pend_reg <= rd_pend_next;
			wr_sel_reg <= wr_sel_next;
			rd_sel_reg <= rd_sel_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= hreadyout_next;
			st_reg <= st_next;
			cur_reg <= cur_next;
			mreq_reg <= mreq_next;
			preq_reg <= preq_next;
			ack_reg <= ack_next;
		end
	end

	assign hreadyout = hreadyout_reg;
	assign hrdata = hrdata_reg;
	// Only OKAY is ever answered; hsize is not checked, word access assumed
	assign hresp = 1'b0;
	assign periph_ack = ack_reg;
	assign per_req = preq_reg;
	assign mem_req = mreq_reg;
	assign chan_irq = irq_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	ack_one_pulse_a: assert property (|ack_reg |=> ack_reg == 16'h0000)
		else $error("acknowledge longer than one cycle");
	ack_on_start_a: assert property (st_reg == S_IDLE && clk_run && gv |=> |ack_reg)
		else $error("no acknowledge at transfer start");
	cnt_step_a: assert property (xfer_done && !wr_pend_reg
		&& cnt_reg[cur_reg] != 16'h0000
		|=> cnt_reg[$past(cur_reg)] == $past(cnt_reg[cur_reg]) - 16'h0001)
		else $error("item counter did not step by one");
	ptr_step_a: assert property (xfer_done && !wr_pend_reg
		&& cnt_reg[cur_reg] != 16'h0000 |=> ptr_reg[$past(cur_reg)]
		== $past(ptr_reg[cur_reg]) + step($past(mode_reg[cur_reg][1:0])))
		else $error("memory pointer did not advance by width");
	// Every channel is watched, so whichever one a scenario reloads is covered
	for (genvar g = 0; g < NCH; g++)
	begin : g_reload
		reload_copy_a: assert property (cnt_reg[g] == 16'h0000 && rcnt_reg[g] != 16'h0000
			&& !wr_pend_reg
			|=> cnt_reg[g] == $past(rcnt_reg[g]) && ptr_reg[g] == $past(rptr_reg[g]))
			else $error("reload not copied");
		reload_clear_a: assert property (cnt_reg[g] == 16'h0000 && rcnt_reg[g] != 16'h0000
			&& !mode_reg[g][`PDC_BIT_WRAP] && !wr_pend_reg
			|=> rcnt_reg[g] == 16'h0000 && rptr_reg[g] == 32'h0000_0000)
			else $error("reload values not cleared");
		wrap_keep_a: assert property (cnt_reg[g] == 16'h0000 && rcnt_reg[g] != 16'h0000
			&& mode_reg[g][`PDC_BIT_WRAP] && !wr_pend_reg
			|=> $stable(rcnt_reg[g]) && $stable(rptr_reg[g]))
			else $error("wrap mode lost reload values");
	end
	prio_low_a: assert property (gv && on_reg[0] && !err_reg[0]
		&& cnt_reg[0] != 16'h0000 && periph_req[psel_reg[0][3:0]] |-> gch == '0)
		else $error("channel zero not preferred");
	err_stop_a: assert property (gv |-> !err_reg[gch] && on_reg[gch])
		else $error("stopped channel granted");
	err_set_a: assert property (xfer_err |=> err_reg[$past(cur_reg)])
		else $error("error flag not set");
	byte_zero_a: assert property (preq_reg.stb && preq_reg.we
		&& mode_reg[cur_reg][1:0] == 2'h0 |-> preq_reg.wdata[31:8] == 24'h00_0000)
		else $error("upper peripheral bits not zero");
	freeze_a: assert property (!clk_run |=> $stable(st_reg) && ack_reg == 16'h0000)
		else $error("engine moved while held");
	read_wait_a: assert property (hsel && hready && htrans == 2'h2 && !hwrite
		|=> !hreadyout_reg ##1 hreadyout_reg)
		else $error("read answer timing wrong");
	cov_done_c: cover property (xfer_done);
	cov_reload_c: cover property (cnt_reg[0] == 16'h0000 && rcnt_reg[0] != 16'h0000);
	cov_err_c: cover property (xfer_err);
	cov_p2m_c: cover property (st_reg == S_PCAP ##1 st_reg == S_MWR);
endmodule
`default_nettype wire

//--- sim/pdc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pdc_partner #(
	parameter logic [31:0] MPAT = 32'hD4C3_B2A1,
	parameter logic [31:0] PPAT = 32'h5E6F_7A8B,
	parameter int LAT = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire pdc_pkg::pdc_mem_req_t mem_req,
	output pdc_pkg::pdc_mem_rsp_t mem_rsp,
	input wire pdc_pkg::pdc_per_req_t per_req,
	output logic [31:0] per_rdata,
	output logic [31:0] last_pw,
	output logic [31:0] last_ma,
	output logic [31:0] last_md
);
	import pdc_pkg::*;
	logic [3:0] wait_cnt;
	logic give;
	// Answer only after LAT idle cycles so the engine sees real wait states
	assign give = mem_req.valid && !mem_rsp.ack && (wait_cnt >= LAT[3:0]);
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_rsp <= '0;
			per_rdata <= ~PPAT;
			wait_cnt <= 4'h0;
			last_pw <= '0;
			last_ma <= '0;
			last_md <= '0;
		end
		else
		begin
			mem_rsp.ack <= give;
			// Top region of the map is not backed by memory
			mem_rsp.err <= give && (mem_req.addr[31:28] == 4'hF);
			// Bus lines outside an answer toggle, never hold stale data
			mem_rsp.rdata <= give ? MPAT : ~mem_rsp.rdata;
			wait_cnt <= (mem_req.valid && !give && !mem_rsp.ack) ? wait_cnt + 4'h1 : 4'h0;
			per_rdata <= (per_req.stb && !per_req.we) ? PPAT : ~PPAT;
			if (give && mem_req.write)
			begin
				last_ma <= mem_req.addr;
				last_md <= mem_req.wdata;
			end
			if (per_req.stb && per_req.we)
				last_pw <= per_req.wdata;
		end
	end
endmodule
`default_nettype wire

//--- sim/peripheral_dma_channel_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pdc_consts.svh"
module peripheral_dma_channel_test;
	import pdc_pkg::*;
	localparam logic [31:0] MPAT = 32'hD4C3_B2A1;
	localparam logic [31:0] PPAT = 32'h5E6F_7A8B;
	logic ref_clk;
	logic rst_n;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic hresp;
	logic clk_run;
	logic [15:0] periph_req;
	logic [15:0] periph_ack;
	pdc_per_req_t per_req;
	logic [31:0] per_rdata;
	pdc_mem_req_t mem_req;
	pdc_mem_rsp_t mem_rsp;
	logic [3:0] chan_irq;
	logic [31:0] last_pw, last_ma, last_md;
	int err_total;
	int num_checks;
	int acks;

	pdc_top #(.NCH(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clk_run(clk_run),
		.periph_req(periph_req), .periph_ack(periph_ack), .per_req(per_req),
		.per_rdata(per_rdata), .mem_req(mem_req), .mem_rsp(mem_rsp), .chan_irq(chan_irq));
	pdc_partner #(.MPAT(MPAT), .PPAT(PPAT), .LAT(2)) partner (.ref_clk(ref_clk), .rst_n(rst_n),
		.mem_req(mem_req), .mem_rsp(mem_rsp), .per_req(per_req), .per_rdata(per_rdata),
		.last_pw(last_pw), .last_ma(last_ma), .last_md(last_md));

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		acks <= acks + $countones(periph_ack);

	// ----------------------------------------
	// Bus and check helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [31:0] ra(input int ch, input logic [5:0] off);
		return {20'h0, ch[5:0], off};
	endfunction
	task automatic bw(input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= `PDC_AHB_NONSEQ;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
	endtask
	task automatic br(input logic [31:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= `PDC_AHB_NONSEQ;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic rc(input logic [31:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		br(a, d);
		chk(what, d, exp);
	endtask
	// Bounded poll: gives up after 60 reads and reports the last value
	task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
		logic [31:0] d;
		for (int i = 0; i < 60; i++)
		begin
			br(a, d);
			if ((d & m) === v)
				return;
		end
		chk("poll", d & m, v);
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		bw(ra(0, `PDC_OFF_PTR), 32'h1234_5678);
		rc(ra(0, `PDC_OFF_PTR), 32'h1234_5678, "pointer");
		bw(ra(0, `PDC_OFF_MSET), 32'h0000_0007);
		bw(ra(0, `PDC_OFF_MCLR), 32'h0000_0005);
		rc(ra(0, `PDC_OFF_MASK), 32'h0000_0002, "mask");
		rc(ra(0, `PDC_OFF_STATE), 32'h0000_0000, "state");
		bw(32'h0000_0FC0, 32'hFFFF_FFFF);
		rc(32'h0000_0FC0, 32'h0000_0000, "unmapped");
		chk("response", {31'h0, hresp}, 32'h0);
	endtask
	task automatic t_m2p();
		int a0;
		a0 = acks;
		bw(ra(0, `PDC_OFF_PSEL), 32'h0000_0002);
		bw(ra(0, `PDC_OFF_MODE), {30'h0, `PDC_W_BYTE});
		bw(ra(0, `PDC_OFF_PTR), 32'h0000_0100);
		bw(ra(0, `PDC_OFF_CTRL), 32'h0000_0001);
		rc(ra(0, `PDC_OFF_STATE), 32'h0000_0001, "state on");
		bw(ra(0, `PDC_OFF_CNT), 32'h0000_0002);
		poll(ra(0, `PDC_OFF_CNT), 32'h0000_FFFF, 32'h0);
		rc(ra(0, `PDC_OFF_PTR), 32'h0000_0102, "byte pointer");
		chk("periph data", last_pw, {24'h0, MPAT[15:8]});
		chk("ack pulses", acks - a0, 32'd2);
		rc(ra(0, `PDC_OFF_FLAGS), 32'h0000_0003, "flags done");
		chk("irq", {31'h0, chan_irq[0]}, 32'h1);
		bw(ra(0, `PDC_OFF_CTRL), 32'h0000_0002);
		rc(ra(0, `PDC_OFF_STATE), 32'h0000_0000, "state off");
	endtask
	task automatic t_reload();
		bw(ra(1, `PDC_OFF_PSEL), 32'h0000_0011);
		bw(ra(1, `PDC_OFF_MODE), {30'h0, `PDC_W_WORD});
		bw(ra(1, `PDC_OFF_RPTR), 32'h0000_0200);
		bw(ra(1, `PDC_OFF_RCNT), 32'h0000_0001);
		rc(ra(1, `PDC_OFF_PTR), 32'h0000_0200, "loaded pointer");
		rc(ra(1, `PDC_OFF_CNT), 32'h0000_0001, "loaded count");
		bw(ra(1, `PDC_OFF_RPTR), 32'h0000_0400);
		bw(ra(1, `PDC_OFF_RCNT), 32'h0000_0002);
		bw(ra(1, `PDC_OFF_CTRL), 32'h0000_0001);
		// Count is zero for a cycle before the reload, so wait for finished instead
		poll(ra(1, `PDC_OFF_FLAGS), 32'h0000_0002, 32'h2);
		rc(ra(1, `PDC_OFF_CNT), 32'h0000_0000, "count spent");
		rc(ra(1, `PDC_OFF_PTR), 32'h0000_0408, "reload pointer");
		rc(ra(1, `PDC_OFF_RCNT), 32'h0000_0000, "reload cleared");
		chk("mem addr", last_ma, 32'h0000_0404);
		chk("mem data", last_md, PPAT);
		bw(ra(1, `PDC_OFF_MODE), {29'h0, 1'b1, `PDC_W_WORD});
		bw(ra(1, `PDC_OFF_RPTR), 32'h0000_0500);
		bw(ra(1, `PDC_OFF_RCNT), 32'h0000_0001);
		repeat (20) @(posedge ref_clk);
		rc(ra(1, `PDC_OFF_RCNT), 32'h0000_0001, "wrap count");
		rc(ra(1, `PDC_OFF_RPTR), 32'h0000_0500, "wrap pointer");
	endtask
	// Channel 1 still loops in wrap mode when this starts
	task automatic t_freeze();
		logic [31:0] p0, c0, p1, c1;
		int a0;
		clk_run <= 1'b0;
		repeat (8) @(posedge ref_clk);
		br(ra(1, `PDC_OFF_PTR), p0);
		br(ra(1, `PDC_OFF_CNT), c0);
		repeat (20) @(posedge ref_clk);
		a0 = acks;
		br(ra(1, `PDC_OFF_PTR), p1);
		br(ra(1, `PDC_OFF_CNT), c1);
		chk("held pointer", p1, p0);
		chk("held count", c1, c0);
		chk("held acks", acks - a0, 32'd0);
		clk_run <= 1'b1;
		repeat (40) @(posedge ref_clk);
		chk("resumed acks", {31'h0, acks > a0}, 32'h1);
		bw(ra(1, `PDC_OFF_CTRL), 32'h0000_0002);
		repeat (10) @(posedge ref_clk);
		rc(ra(1, `PDC_OFF_STATE), 32'h0000_0000, "off before sleep");
		clk_run <= 1'b0;
		repeat (5) @(posedge ref_clk);
		clk_run <= 1'b1;
	endtask
	task automatic t_err();
		bw(ra(0, `PDC_OFF_MODE), {30'h0, `PDC_W_WORD});
		bw(ra(0, `PDC_OFF_PTR), 32'hF000_0000);
		bw(ra(0, `PDC_OFF_CTRL), 32'h0000_0001);
		bw(ra(0, `PDC_OFF_CNT), 32'h0000_0001);
		poll(ra(0, `PDC_OFF_FLAGS), 32'h0000_0004, 32'h4);
		rc(ra(0, `PDC_OFF_CNT), 32'h0000_0001, "count held");
		bw(ra(0, `PDC_OFF_PTR), 32'h0000_0600);
		bw(ra(0, `PDC_OFF_CTRL), 32'h0000_0100);
		poll(ra(0, `PDC_OFF_CNT), 32'h0000_FFFF, 32'h0);
		rc(ra(0, `PDC_OFF_PTR), 32'h0000_0604, "resumed");
		bw(ra(0, `PDC_OFF_MCLR), 32'h0000_0007);
		repeat (3) @(posedge ref_clk);
		chk("irq masked", {31'h0, chan_irq[0]}, 32'h0);
	endtask
	task automatic t_half();
		bw(ra(2, `PDC_OFF_PSEL), 32'h0000_0002);
		bw(ra(2, `PDC_OFF_MODE), {30'h0, `PDC_W_HALF});
		bw(ra(2, `PDC_OFF_PTR), 32'h0000_0702);
		bw(ra(2, `PDC_OFF_CTRL), 32'h0000_0001);
		bw(ra(2, `PDC_OFF_CNT), 32'h0000_0001);
		poll(ra(2, `PDC_OFF_CNT), 32'h0000_FFFF, 32'h0);
		rc(ra(2, `PDC_OFF_PTR), 32'h0000_0704, "half pointer");
		chk("half data", last_pw, {16'h0, MPAT[31:16]});
	endtask

	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		clk_run = 1'b1;
		// peripherals 1 and 2 always ready
		periph_req = 16'h0006;
		err_total = 0;
		num_checks = 0;
		acks = 0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		t_regs();
		t_m2p();
		t_reload();
		t_freeze();
		t_err();
		t_half();
		end_of_test();
	end
	// Whole run needs a few hundred cycles; this is a generous margin
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		err_total++;
		end_of_test();
	end
endmodule
`default_nettype wire
